// ### rtl/alo_defs.vh
// Constants for the alarm output line block: register offsets, fields,
// reset values and counts.
// Assumes inclusion by bare name from the rtl files.
`ifndef ALO_DEFS_VH
`define ALO_DEFS_VH
`define ALO_NUM_LINES 4
`define ALO_NUM_CHAN 8
`define ALO_MAP_W 3
`define ALO_ADDR_W 8
`define ALO_OFF_CTRL 8'h00
`define ALO_OFF_CLEAR 8'h04
`define ALO_OFF_LINES 8'h08
`define ALO_OFF_STAT 8'h0C
`define ALO_OFF_MASK 8'h10
`define ALO_OFF_MAP 8'h14
`define ALO_CTRL_FOLLOW 0
`define ALO_CTRL_POS 1
`define ALO_CLR_ALL 4
`define ALO_CTRL_RST 2'h0
`define ALO_MASK_RST 4'h0
`define ALO_MAP_RST 32'h0000_0000
`define ALO_ZERO 32'h0000_0000
`endif

// ### rtl/alo_line.v
// One alarm output line: sticky or follow state for a line.
// Assumes the caller forms the OR of mapped channel events each cycle.
module alo_line
(
  // Clock and reset.
  input wire sys_clk_in,
  input wire rst_in,
  // Control.
  input wire any_in,
  input wire follow_in,
  input wire clear_in,
  // State.
  output reg state_out
);
  always @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
      state_out <= 1'b0;
    else if (follow_in)
      state_out <= any_in;
    else if (any_in)
      state_out <= 1'b1;
    else if (clear_in)
      state_out <= 1'b0;
  end
endmodule // alo_line

// ### rtl/alo_top.v
// Alarm output block: four alarm lines driven by per-channel limit events,
// with an APB register slave and a level interrupt.
// Assumes channel violation inputs are registered and synchronous.
`include "alo_defs.vh"

module alo_top
#(
  parameter NUM_CHAN = `ALO_NUM_CHAN
)
(
  // Clock and reset.
  input wire sys_clk_in,
  input wire rst_in,
  // APB slave.
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [`ALO_ADDR_W-1:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  // Measurement side.
  input wire [NUM_CHAN-1:0] chan_viol_in,
  input wire scan_start_in,
  // Alarm lines and interrupt.
  output reg [`ALO_NUM_LINES-1:0] alarm_line_out,
  output reg irq_out
);
  localparam NL = `ALO_NUM_LINES;
  localparam MW = `ALO_MAP_W;

  // Configuration registers.
  reg follow;
  reg pos_pol;
  reg [NL-1:0] mask;
  reg [MW*NUM_CHAN-1:0] chan_map;

  // Line pipeline and sticky status.
  reg [NL-1:0] line_any;
  reg [NL-1:0] clear_pulse;
  reg [NL-1:0] alarm_seen;
  reg [NL-1:0] stat;

  // Bus decode and read data.
  reg [31:0] next_rdata;
  reg addr_ok;
  wire access;
  wire wr_en;
  wire rd_en;
  wire rd_stat;
  wire sel_ctrl;
  wire sel_clear;
  wire sel_lines;
  wire sel_stat;
  wire sel_mask;
  wire sel_map;
  wire clear_all;
  wire [MW-1:0] clear_num;
  wire next_ready;
  wire next_slverr;
  wire next_irq;

  // Read values of each register, zero-extended to the bus width.
  wire [31:0] rd_ctrl;
  wire [31:0] rd_lines;
  wire [31:0] rd_stat_val;
  wire [31:0] rd_mask;
  wire [31:0] rd_map;

  // Per-line and per-channel nets.
  wire [NL*NUM_CHAN-1:0] chan_hit;
  wire [NL-1:0] next_line_any;
  wire [NL-1:0] next_clear;
  wire [NL-1:0] next_stat;
  wire [NL-1:0] next_alarm_line;
  wire [NL-1:0] line_clear;
  wire [NL-1:0] line_rise;
  wire [NL-1:0] line_state;

  // APB access phase; pready rises one cycle after the first access
  // edge, so every transfer has exactly one wait state.
  assign access = psel_in & penable_in & ~pready_out;
  assign wr_en = access & pwrite_in;
  assign rd_en = access & ~pwrite_in;

  assign sel_ctrl = (paddr_in == `ALO_OFF_CTRL);
  assign sel_clear = (paddr_in == `ALO_OFF_CLEAR);
  assign sel_lines = (paddr_in == `ALO_OFF_LINES);
  assign sel_stat = (paddr_in == `ALO_OFF_STAT);
  assign sel_mask = (paddr_in == `ALO_OFF_MASK);
  assign sel_map = (paddr_in == `ALO_OFF_MAP);
  assign rd_stat = rd_en & sel_stat;

  always @*
  begin
    case (paddr_in)
      `ALO_OFF_CTRL,
      `ALO_OFF_CLEAR,
      `ALO_OFF_LINES,
      `ALO_OFF_STAT,
      `ALO_OFF_MASK,
      `ALO_OFF_MAP: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  assign rd_ctrl = {30'h0000_0000, pos_pol, follow};
  assign rd_lines = {{(32-NL){1'b0}}, line_state};
  assign rd_stat_val = {{(32-NL){1'b0}}, stat};
  assign rd_mask = {{(32-NL){1'b0}}, mask};
  assign rd_map = {{(32-MW*NUM_CHAN){1'b0}}, chan_map};

  // Clear register: value 1..4 clears one line, bit 4 clears all.
  assign clear_all = pwdata_in[`ALO_CLR_ALL];
  assign clear_num = pwdata_in[MW-1:0];

  assign next_ready = access;
  assign next_slverr = access & ~addr_ok;
  assign next_irq = |(stat & mask);

  // Map value 0 or 5..7 leaves a channel unassigned; 1..4 name a line.
  genvar c;
  genvar g;
  generate
    for (c = 0; c < NUM_CHAN; c = c + 1)
    begin : gen_chan
      for (g = 0; g < NL; g = g + 1)
      begin : gen_hit
        localparam [MW-1:0] LINE_NUM = g + 1;
        assign chan_hit[g*NUM_CHAN+c] = chan_viol_in[c] &
          (chan_map[c*MW +: MW] == LINE_NUM);
      end
    end
  endgenerate

  // Per line: OR of mapped channels, clear decode, state and status.
  generate
    for (g = 0; g < NL; g = g + 1)
    begin : gen_line
      localparam [MW-1:0] LINE_NUM = g + 1;
      assign next_line_any[g] = |chan_hit[g*NUM_CHAN +: NUM_CHAN];
      assign next_clear[g] = wr_en & sel_clear &
        (clear_all | (clear_num == LINE_NUM));
      assign line_clear[g] = clear_pulse[g] | scan_start_in;
      assign line_rise[g] = line_state[g] & ~alarm_seen[g];
      // A line rising sets its status bit; the set wins over a read.
      assign next_stat[g] = (stat[g] & ~rd_stat) |
        line_rise[g];
      assign next_alarm_line[g] = pos_pol ? line_state[g] :
        ~line_state[g];
      alo_line u_line
      (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .any_in(line_any[g]),
        .follow_in(follow),
        .clear_in(line_clear[g]),
        .state_out(line_state[g])
      );
    end
  endgenerate

  always @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      line_any <= {NL{1'b0}};
    end
    else
    begin
      line_any <= next_line_any;
    end
  end

  always @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      clear_pulse <= {NL{1'b0}};
    end
    else
    begin
      clear_pulse <= next_clear;
    end
  end

  // Control register: bit 0 selects follow mode, bit 1 high polarity.
  always @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      follow <= 1'b0;
    end
    else if (wr_en && sel_ctrl)
    begin
      follow <= pwdata_in[`ALO_CTRL_FOLLOW];
    end
  end

  always @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pos_pol <= 1'b0;
    end
    else if (wr_en && sel_ctrl)
    begin
      pos_pol <= pwdata_in[`ALO_CTRL_POS];
    end
  end

  always @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      mask <= `ALO_MASK_RST;
    end
    else if (wr_en && sel_mask)
    begin
      mask <= pwdata_in[NL-1:0];
    end
  end

  always @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      chan_map <= {MW*NUM_CHAN{1'b0}};
    end
    else if (wr_en && sel_map)
    begin
      chan_map <= pwdata_in[MW*NUM_CHAN-1:0];
    end
  end

  always @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      stat <= {NL{1'b0}};
    end
    else
    begin
      stat <= next_stat;
    end
  end

  always @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      alarm_seen <= {NL{1'b0}};
    end
    else
    begin
      alarm_seen <= line_state;
    end
  end

  always @*
  begin
    next_rdata = `ALO_ZERO;
    case (paddr_in)
      `ALO_OFF_CTRL: next_rdata = rd_ctrl;
      `ALO_OFF_LINES: next_rdata = rd_lines;
      `ALO_OFF_STAT: next_rdata = rd_stat_val;
      `ALO_OFF_MASK: next_rdata = rd_mask;
      `ALO_OFF_MAP: next_rdata = rd_map;
      default: next_rdata = `ALO_ZERO;
    endcase
  end

  // Every output below comes straight from a flip-flop.
  always @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pready_out <= 1'b0;
    end
    else
    begin
      pready_out <= next_ready;
    end
  end

  always @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pslverr_out <= 1'b0;
    end
    else
    begin
      pslverr_out <= next_slverr;
    end
  end

  always @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      prdata_out <= `ALO_ZERO;
    end
    else
    begin
      prdata_out <= rd_en ? next_rdata : `ALO_ZERO;
    end
  end

  always @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      alarm_line_out <= {NL{1'b0}};
    end
    else
    begin
      alarm_line_out <= next_alarm_line;
    end
  end

  always @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      irq_out <= 1'b0;
    end
    else
    begin
      irq_out <= next_irq;
    end
  end
endmodule // alo_top

// ### verif/alo_lamp.sv
// Far-side lamp model: lights a lamp for each active alarm line.
// Assumes the observer knows the polarity setting.
module alo_lamp
(
  input wire logic [3:0] line_in,
  input wire logic pos_in,
  output logic [3:0] lit_out
);
  assign lit_out = pos_in ? line_in : ~line_in;
endmodule // alo_lamp

// ### verif/alo_top_bench.sv
// Self-checking bench for the alarm output block with a lamp model.
// Assumes a 250 MHz clock and an APB slave with one wait state.
module alo_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_in = 0;
  logic rst_in = 1;
  logic psel_in = 0;
  logic penable_in = 0;
  logic pwrite_in = 0;
  logic [7:0] paddr_in = '0;
  logic [31:0] pwdata_in = '0;
  logic [7:0] chan_viol_in = '0;
  logic scan_start_in = 0;
  logic [31:0] prdata_out;
  logic pready_out;
  logic pslverr_out;
  logic [3:0] alarm_line_out;
  logic irq_out;
  logic [3:0] lit;
  logic pos = 0;
  logic [31:0] rd;
  logic err;
  logic [23:0] m;
  logic [7:0] v;
  logic [3:0] e;
  integer errors = 0;
  integer samples_checked = 0;
  integer seed = 31398;
  integer i;
  always #2 sys_clk_in = ~sys_clk_in;
  alo_top dut_u (.*);
  alo_lamp lamp_u (.line_in(alarm_line_out), .pos_in(pos), .lit_out(lit));
  task automatic w(input integer n);
    repeat (n) @(posedge sys_clk_in);
  endtask
  task automatic chk(input [31:0] got, input [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input w_in, input [7:0] a, input [31:0] d);
    psel_in <= 1;
    pwrite_in <= w_in;
    paddr_in <= a;
    pwdata_in <= d;
    w(1);
    penable_in <= 1;
    w(1);
    while (pready_out !== 1'b1)
      w(1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 0;
    penable_in <= 0;
    w(1);
  endtask
  task automatic hit(input [7:0] c);
    chan_viol_in <= c;
    w(1);
    chan_viol_in <= '0;
    w(6);
  endtask
  function automatic [3:0] want(input [7:0] c, input [23:0] mp);
    want = '0;
    for (int k = 0; k < 8; k++)
      if (c[k] && mp[3*k+:3] >= 1 && mp[3*k+:3] <= 4)
        want[mp[3*k+:3]-1] = 1;
  endfunction
  task automatic end_sim;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #20000;
    errors++;
    end_sim;
  end
  initial
  begin
    w(20);
    rst_in <= 0;
    w(2);
    chk(lit, 4'h0);
    bus(0, 8'h14, 0);
    chk(rd, 32'h0000_0000);
    m = $random(seed);
    m[2:0] = 3'h1;
    v = $random(seed) | 1;
    e = want(v, m);
    bus(1, 8'h14, m);
    bus(0, 8'h14, 0);
    chk(rd, {8'h00, m});
    hit(v);
    chk(lit, e);
    for (i = 1; i < 5; i++)
    begin
      bus(1, 8'h04, i);
      e[i-1] = 0;
      w(6);
      chk(lit, e);
    end
    hit(v);
    bus(1, 8'h04, 32'h0000_0010);
    w(6);
    chk(lit, 4'h0);
    hit(v);
    scan_start_in <= 1;
    w(1);
    scan_start_in <= 0;
    w(6);
    chk(lit, 4'h0);
    e = want(v, m);
    bus(1, 8'h00, 1);
    chan_viol_in <= v;
    w(6);
    chk(lit, e);
    chan_viol_in <= '0;
    w(6);
    chk(lit, 4'h0);
    bus(0, 8'h0c, 0);
    bus(1, 8'h00, 3);
    bus(0, 8'h00, 0);
    chk(rd, 32'h0000_0003);
    pos <= 1;
    chan_viol_in <= v;
    w(6);
    chk(alarm_line_out, e);
    bus(1, 8'h10, 32'h0000_000f);
    w(3);
    chk(irq_out, 1);
    bus(0, 8'h0c, 0);
    chk(rd, e);
    w(3);
    chk(irq_out, 0);
    bus(0, 8'h40, 0);
    chk(err, 1);
    end_sim;
  end
endmodule // alo_top_bench

// ### verif/alo_top_sva.sv
// Port checker for the alarm output block.
// Assumes one clock domain and the asynchronous reset.
module alo_top_chk
#(
  parameter NUM_CHAN = 8
)
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [7:0] paddr_in,
  input wire logic [NUM_CHAN-1:0] chan_viol_in,
  input wire logic scan_start_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [3:0] alarm_line_out,
  input wire logic irq_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  a_ready_follows: assert property (
    psel_in && penable_in && !pready_out |=> pready_out) else $error("late");
  a_ready_pulse: assert property (
    pready_out |=> !pready_out) else $error("long ready");
  a_err_ready: assert property (
    pslverr_out |-> pready_out) else $error("lone error");
  a_idle_rdata: assert property (
    !pready_out |-> prdata_out == 0) else $error("idle data");
  a_unmapped_err: assert property (
    psel_in && penable_in && !pready_out && paddr_in > 8'h14
    |=> pslverr_out) else $error("no error");
  a_mapped_ok: assert property (
    psel_in && penable_in && !pready_out && paddr_in <= 8'h14
    && paddr_in[1:0] == 0 |=> !pslverr_out) else $error("bad error");
  a_lines_hold: assert property (
    ($stable(chan_viol_in) && !psel_in && !scan_start_in)[*6]
    |-> $stable(alarm_line_out)) else $error("line moved");
  a_irq_hold: assert property (
    ($stable(chan_viol_in) && !psel_in && !scan_start_in)[*6]
    |-> $stable(irq_out)) else $error("irq moved");
endmodule // alo_top_chk
bind alo_top alo_top_chk #(.NUM_CHAN(NUM_CHAN)) chk_u (.*);
